// >>> src/tec_pkg.sv
package tec_pkg;
   // register word indices on the avalon slave (word addressing)
   localparam logic [1:0] TEC_IDX_COUNT = 2'h0; // read count, write preload
   localparam logic [1:0] TEC_IDX_CTRL = 2'h1; // timer control register
   // control register field positions
   localparam int TEC_MODE_HI = 7;
   localparam int TEC_MODE_LO = 6;
   localparam int TEC_SRC_BIT = 5;
   localparam int TEC_EN_BIT = 4;
   localparam int TEC_EDGE_BIT = 3;
   localparam int TEC_PSC_HI = 2;
   localparam int TEC_PSC_LO = 0;
   // reset values
   localparam logic [7:0] TEC_CTRL_RST = 8'h08; // edge select reads one
   localparam logic [7:0] TEC_COUNT_RST = 8'h00;
   localparam logic [7:0] TEC_FULL = 8'hFF; // full count, overflow point
   // mode field encodings
   localparam logic [1:0] TEC_MODE_NONE = 2'h0;
   localparam logic [1:0] TEC_MODE_EVENT = 2'h1;
   localparam logic [1:0] TEC_MODE_TIMER = 2'h2;
   localparam logic [1:0] TEC_MODE_CAPTURE = 2'h3;
   // pulse capture sequencing
   typedef enum logic [1:0] {
      TEC_CAP_IDLE,
      TEC_CAP_ARMED,
      TEC_CAP_MEASURE
   } tec_cap_t;
endpackage

// >>> src/tec_timer.sv
`timescale 1ns/100ps
// Notes on behaviour
// R1: counter is eight bits, counting up
// R2: three software modes: timer, event, capture
// R3: reading count register returns live count
// R4: timer and capture modes use internal clock
// R5: three-bit field sets prescaler ratio
// R6: source bit picks system or crystal clock
// R7: event mode counts pin edges selected
// R8: each internal tick adds one while counting
// R9: count to FF, overflow, raise interrupt
// R10: reload preload after overflow, keep counting
// R11: software clears preload for full range
// R12: preload not initialised at power-on
// R13: stopped: preload write also loads counter
// R14: running: preload write waits for overflow
// R15: software programs control before use
// R16: mode 00 none, 01 event, 10 timer, 11 capture
// R17: event edge 0 rising, 1 falling
// R18: prescale 000 divides 1 up to 128
// R19: capture starts on edge, self-clears enable
// R20: counting only while enable bit set
// R21: event mode bypasses the prescaler
module tec_timer
   import tec_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic external_count_pin,
   input wire logic low_speed_crystal_clock,
   output logic overflow_irq,
   output logic count_active
);

   // bus handshake state
   logic ack_ff; // high in the cycle the request completes
   logic [31:0] rdata_ff; // read data snapshot
   // register state
   logic [7:0] timer_control_register_ff;
   logic [7:0] timer_count_register_ff;
   logic [7:0] preload_ff; // no reset: content unknown at power-on
   logic irq_ff;
   // synchronisers and edge detection
   logic pin_s1_ff;
   logic pin_s2_ff;
   logic pin_s3_ff; // previous synced level, for edges
   logic lxt_s1_ff;
   logic lxt_s2_ff;
   logic lxt_s3_ff;
   // prescaler and capture sequencer
   logic [6:0] pre_cnt_ff;
   tec_cap_t cap_ff;
   tec_cap_t nxt_cap;

   // decoded fields
   logic [1:0] mode_select_pair;
   logic clock_source_select;
   logic count_enable_bit;
   logic active_edge_select;
   logic [2:0] prescale_select;
   // strobes and ticks
   logic wr_done;
   logic ctrl_wr;
   logic pre_wr;
   logic pin_rise;
   logic pin_fall;
   logic src_tick;
   logic [6:0] psc_mask;
   logic int_tick;
   logic start_edge;
   logic stop_edge;
   logic ext_hit;
   logic inc;
   logic wrap;

   assign mode_select_pair = timer_control_register_ff[TEC_MODE_HI:TEC_MODE_LO];
   assign clock_source_select = timer_control_register_ff[TEC_SRC_BIT];
   assign count_enable_bit = timer_control_register_ff[TEC_EN_BIT];
   assign active_edge_select = timer_control_register_ff[TEC_EDGE_BIT];
   assign prescale_select = timer_control_register_ff[TEC_PSC_HI:TEC_PSC_LO];

   // avalon slave: one wait cycle, then the request completes
   // a request seen while ack is high is the one finishing, not a new one
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= (avs_read || avs_write) && !ack_ff;
      end
   end

   // waitrequest held high until the completing cycle
   assign avs_waitrequest = !ack_ff;
   assign avs_readdata = rdata_ff;
   // writes land only at the edge where waitrequest is low
   assign wr_done = ack_ff && avs_write && avs_byteenable[0];
   assign ctrl_wr = wr_done && (avs_address == TEC_IDX_CTRL);
   assign pre_wr = wr_done && (avs_address == TEC_IDX_COUNT);

   // read snapshot taken in the wait cycle; unmapped words read zero
   // the value returned lags the live count by the one wait cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdata_ff <= 32'h00000000;
      end else if (avs_read && !ack_ff) begin
         case (avs_address)
            TEC_IDX_COUNT: rdata_ff <= {24'h000000, timer_count_register_ff}; // R3
            TEC_IDX_CTRL: rdata_ff <= {24'h000000, timer_control_register_ff};
            default: rdata_ff <= 32'h00000000;
         endcase
      end
   end

   // pin and crystal synchronisers; only stage two feeds logic
   // stage three only holds the edge detector's previous level
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pin_s1_ff <= 1'b0;
         pin_s2_ff <= 1'b0;
         pin_s3_ff <= 1'b0;
         lxt_s1_ff <= 1'b0;
         lxt_s2_ff <= 1'b0;
         lxt_s3_ff <= 1'b0;
      end else begin
         pin_s1_ff <= external_count_pin;
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
         lxt_s1_ff <= low_speed_crystal_clock;
         lxt_s2_ff <= lxt_s1_ff;
         lxt_s3_ff <= lxt_s2_ff;
      end
   end

   assign pin_rise = pin_s2_ff && !pin_s3_ff;
   assign pin_fall = !pin_s2_ff && pin_s3_ff;

   // internal source: every core cycle or each crystal rising edge
   // the crystal must run well below half the core rate to be seen
   assign src_tick = clock_source_select ? (lxt_s2_ff && !lxt_s3_ff) : 1'b1; // R6

   // free-running prescaler, divide by two to the power of the code
   // not cleared on enable, so the first divided tick has arbitrary phase
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pre_cnt_ff <= 7'h00;
      end else if (src_tick) begin
         pre_cnt_ff <= pre_cnt_ff + 7'h01;
      end
   end

   // low code bits of the prescaler all ones marks the divided tick
   assign psc_mask = 7'((8'h01 << prescale_select) - 8'h01); // R18
   assign int_tick = src_tick && ((pre_cnt_ff & psc_mask) == psc_mask); // R5

   // capture edges: edge bit low starts on fall, stops on rise
   assign start_edge = active_edge_select ? pin_rise : pin_fall;
   assign stop_edge = active_edge_select ? pin_fall : pin_rise;
   // event edge: edge bit low counts rising, high counts falling
   assign ext_hit = active_edge_select ? pin_fall : pin_rise; // R17

   // capture sequencer: arm on enable, measure between edges
   // it never counts itself; it gates the prescaled tick and, from measure, the enable clear at stop
   always_comb begin
      nxt_cap = cap_ff;
      case (cap_ff)
         TEC_CAP_IDLE: begin
            if (count_enable_bit && mode_select_pair == TEC_MODE_CAPTURE) begin
               nxt_cap = TEC_CAP_ARMED;
            end
         end
         TEC_CAP_ARMED: begin
            if (!count_enable_bit || mode_select_pair != TEC_MODE_CAPTURE) begin
               nxt_cap = TEC_CAP_IDLE;
            end else if (start_edge) begin
               nxt_cap = TEC_CAP_MEASURE; // R19
            end
         end
         TEC_CAP_MEASURE: begin
            if (!count_enable_bit || mode_select_pair != TEC_MODE_CAPTURE || stop_edge) begin
               nxt_cap = TEC_CAP_IDLE; // R19
            end
         end
         default: nxt_cap = TEC_CAP_IDLE;
      endcase
   end

   // capture state register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cap_ff <= TEC_CAP_IDLE;
      end else begin
         cap_ff <= nxt_cap;
      end
   end

   // count qualification per mode; mode none never counts
   // event mode takes the pin edge directly, skipping the prescaler
   always_comb begin
      inc = 1'b0;
      if (count_enable_bit) begin // R20
         case (mode_select_pair) // R2 R16
            TEC_MODE_EVENT: inc = ext_hit; // R7 R21
            TEC_MODE_TIMER: inc = int_tick; // R4 R8
            TEC_MODE_CAPTURE: inc = int_tick && (cap_ff == TEC_CAP_MEASURE); // R4
            default: inc = 1'b0;
         endcase
      end
   end

   assign wrap = inc && (timer_count_register_ff == TEC_FULL); // R9

   // control register; hardware clears enable at capture stop
   // a software write in the same cycle wins, being the newer intent
   always_ff @(posedge core_clk) begin
      if (rst) begin
         timer_control_register_ff <= TEC_CTRL_RST;
      end else if (ctrl_wr) begin
         timer_control_register_ff <= avs_writedata[7:0];
      end else if (cap_ff == TEC_CAP_MEASURE && stop_edge && count_enable_bit
                   && mode_select_pair == TEC_MODE_CAPTURE) begin
         timer_control_register_ff[TEC_EN_BIT] <= 1'b0; // R19
      end
   end

   // preload holds software data only; left without reset on purpose
   always_ff @(posedge core_clk) begin
      if (pre_wr) begin
         preload_ff <= avs_writedata[7:0]; // R12
      end
   end

   // eight-bit up counter with reload on overflow
   // a stopped preload write cannot meet a wrap, since wrap needs enable
   always_ff @(posedge core_clk) begin
      if (rst) begin
         timer_count_register_ff <= TEC_COUNT_RST;
      end else if (pre_wr && !count_enable_bit) begin
         timer_count_register_ff <= avs_writedata[7:0]; // R13
      end else if (wrap) begin
         timer_count_register_ff <= preload_ff; // R10 R14
      end else if (inc) begin
         timer_count_register_ff <= timer_count_register_ff + 8'h01; // R1 R8
      end
   end

   // one-cycle overflow request to the interrupt controller
   // no pending flag here; the interrupt controller latches the request
   // a preload of FF wraps on every tick; with a tick every cycle the request stays high
   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= wrap; // R9
      end
   end

   assign overflow_irq = irq_ff;
   assign count_active = count_enable_bit;

   // all checks run on the core clock and are off during reset
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   AST_WRAP_RELOAD: assert property ( // R10
      wrap && !pre_wr |=> timer_count_register_ff == $past(preload_ff))
      else $error("counter did not reload preload on overflow");

   AST_WRAP_IRQ: assert property ( // R9
      inc && timer_count_register_ff == TEC_FULL |=> overflow_irq)
      else $error("overflow request missing after wrap");

   AST_IRQ_PULSE: assert property ( // R9
      !wrap |=> !overflow_irq)
      else $error("overflow request without a wrap");

   AST_HOLD_OFF: assert property ( // R20
      !count_enable_bit && !pre_wr |=> $stable(timer_count_register_ff))
      else $error("counter moved while disabled");

   AST_EVENT_STEP: assert property ( // R7
      count_enable_bit && mode_select_pair == TEC_MODE_EVENT && ext_hit && !pre_wr
      && timer_count_register_ff != TEC_FULL
      |=> timer_count_register_ff == $past(timer_count_register_ff) + 8'h01)
      else $error("event edge did not advance the counter");

   AST_STOPPED_LOAD: assert property ( // R13
      pre_wr && !count_enable_bit |=> timer_count_register_ff == $past(avs_writedata[7:0]))
      else $error("stopped preload write not copied to counter");

   AST_RUN_PRELOAD: assert property ( // R14
      pre_wr && count_enable_bit && !inc |=> $stable(timer_count_register_ff))
      else $error("running preload write disturbed the counter");

   AST_CAP_STOP: assert property ( // R19
      cap_ff == TEC_CAP_MEASURE && stop_edge && count_enable_bit && !ctrl_wr
      && mode_select_pair == TEC_MODE_CAPTURE |=> !count_enable_bit && cap_ff == TEC_CAP_IDLE)
      else $error("capture stop did not clear enable");

   AST_NO_MODE: assert property ( // R16
      mode_select_pair == TEC_MODE_NONE && !pre_wr |=> $stable(timer_count_register_ff))
      else $error("counter advanced with no mode selected");

   AST_TIMER_PIN: assert property ( // R4
      mode_select_pair == TEC_MODE_TIMER && !int_tick && !pre_wr
      |=> $stable(timer_count_register_ff))
      else $error("timer mode advanced without an internal tick");

   AST_PSC_TICK: assert property ( // R5
      int_tick && prescale_select == 3'h7 |-> pre_cnt_ff == 7'h7F)
      else $error("divide by 128 tick at wrong prescaler phase");

   AST_READ_COUNT: assert property ( // R3
      avs_read && !ack_ff && avs_address == TEC_IDX_COUNT
      |=> !avs_waitrequest && avs_readdata[7:0] == $past(timer_count_register_ff))
      else $error("count read returned a stale value");

   AST_CAP_ARMED_HOLD: assert property ( // R19
      cap_ff == TEC_CAP_ARMED && mode_select_pair == TEC_MODE_CAPTURE && !pre_wr
      |=> $stable(timer_count_register_ff))
      else $error("capture counted before its start edge");

   AST_CRYSTAL_GATE: assert property ( // R6
      clock_source_select && !(lxt_s2_ff && !lxt_s3_ff) |-> !int_tick)
      else $error("crystal source ticked without a crystal edge");

   AST_CTRL_WRITE: assert property ( // R2
      ctrl_wr |=> timer_control_register_ff == $past(avs_writedata[7:0]))
      else $error("control write did not land");

   AST_EVENT_BYPASS: assert property ( // R21
      count_enable_bit && mode_select_pair == TEC_MODE_EVENT && !ext_hit && !pre_wr
      |=> $stable(timer_count_register_ff))
      else $error("event mode advanced without a pin edge");

   AST_PRE_WRITE: assert property ( // R14
      pre_wr |=> preload_ff == $past(avs_writedata[7:0]))
      else $error("preload write did not land");

endmodule // tec_timer

// >>> verif/tec_pin_src.sv
`timescale 1ns/100ps
// stand-in for the signal source on the external count pin
module tec_pin_src (
   input wire logic core_clk,
   output logic pin
);
   initial pin = 1'b0; // idle low between pulses

   // step the pin, then hold it past the 3-cycle sync path
   task automatic level(input logic v, input int w);
      pin <= v;
      repeat (w) @(posedge core_clk);
   endtask

   // n complete high-then-low pulses
   task automatic pulses(input int n);
      repeat (n) begin
         level(1'b1, 6);
         level(1'b0, 6);
      end
   endtask
endmodule // tec_pin_src

// >>> verif/tb.sv
`timescale 1ns/100ps
module tb;
   import tec_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1; // held for 20 cycles
   logic [1:0] avs_address = 2'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, overflow_irq, count_active, pin;
   logic [2:0] xc_ff = 3'h0; // crystal divider, core/8
   logic [7:0] rd;
   int n_fail = 0, samples_checked = 0, cyc = 0, t;

   always #2.5 core_clk = ~core_clk;
   // crystal stays well under core/2 so each rising edge is seen
   always @(posedge core_clk) xc_ff <= xc_ff + 3'h1;

   tec_timer u_dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .external_count_pin(pin),
      .low_speed_crystal_clock(xc_ff[2]), .overflow_irq(overflow_irq),
      .count_active(count_active));
   tec_pin_src u_src (.core_clk(core_clk), .pin(pin));

   task automatic results();
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // hang guard, well above the longest expected run
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_fail++;
         results();
      end
   end

   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_n(input string nm, input int e, input int g);
      samples_checked++;
      if (g != e) begin
         n_fail++;
         $display("Error %s expected %0d seen %0d", nm, e, g);
      end
   endtask

   // one avalon transfer; an extra edge after release avoids re-driving same step
   task automatic bus(input logic wr, input logic [1:0] a, input logic [7:0] d,
                      input logic [3:0] be);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= ~wr;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0) @(posedge core_clk);
      rd = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask

   task automatic rd_chk(input string nm, input logic [1:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00, 4'hF);
      chk8(nm, e, rd);
   endtask

   // cycles between two overflow pulses
   task automatic period(output int n);
      while (overflow_irq !== 1'b1) @(posedge core_clk);
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (overflow_irq !== 1'b1);
   endtask

   initial begin
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      rd_chk("ctrl_rst", TEC_IDX_CTRL, TEC_CTRL_RST);
      rd_chk("count_rst", TEC_IDX_COUNT, TEC_COUNT_RST);
      wr(2'h2, 8'h55);
      rd_chk("unmapped", 2'h2, 8'h00);
      bus(1'b1, TEC_IDX_CTRL, 8'h90, 4'h0);
      rd_chk("ctrl_no_be", TEC_IDX_CTRL, TEC_CTRL_RST);
      wr(TEC_IDX_COUNT, 8'hF0);
      rd_chk("stopped_load", TEC_IDX_COUNT, 8'hF0);
      // every prescale code, 16 ticks from F0 to wrap
      for (int p = 0; p < 8; p++) begin
         wr(TEC_IDX_CTRL, {TEC_MODE_TIMER, 3'h2, p[2:0]});
         period(t); // first interval may straddle the write
         period(t);
         chk_n("timer_period", 16 << p, t);
      end
      wr(TEC_IDX_CTRL, 8'h90);
      period(t);
      wr(TEC_IDX_COUNT, 8'hE0);
      period(t); // a wrap at the write edge still reloads the old preload
      period(t);
      chk_n("running_preload", 32, t);
      wr(TEC_IDX_CTRL, 8'hB0);
      period(t); // first interval may straddle the source change
      period(t);
      chk_n("crystal_period", 256, t);
      // stopped and no-mode must both freeze the count
      wr(TEC_IDX_CTRL, 8'h80);
      wr(TEC_IDX_COUNT, 8'h5A);
      repeat (10) @(posedge core_clk);
      rd_chk("stop_hold", TEC_IDX_COUNT, 8'h5A);
      wr(TEC_IDX_CTRL, 8'h10);
      repeat (10) @(posedge core_clk);
      rd_chk("mode_none", TEC_IDX_COUNT, 8'h5A);
      // event mode with the largest prescale, which must be bypassed
      for (int e = 0; e < 2; e++) begin
         wr(TEC_IDX_CTRL, {TEC_MODE_EVENT, 2'h0, e[0], 3'h7});
         wr(TEC_IDX_COUNT, 8'h00);
         wr(TEC_IDX_CTRL, {TEC_MODE_EVENT, 2'h1, e[0], 3'h7});
         u_src.level(1'b1, 6);
         rd_chk("ev_rise", TEC_IDX_COUNT, {7'h0, ~e[0]});
         u_src.level(1'b0, 6);
         rd_chk("ev_fall", TEC_IDX_COUNT, 8'h01);
         u_src.pulses(4);
         rd_chk("ev_many", TEC_IDX_COUNT, 8'h05);
      end
      // capture a 20-cycle high pulse, start on rising edge
      wr(TEC_IDX_CTRL, 8'hC8);
      wr(TEC_IDX_COUNT, 8'h00);
      wr(TEC_IDX_CTRL, 8'hD8);
      u_src.level(1'b1, 20);
      u_src.level(1'b0, 6);
      bus(1'b0, TEC_IDX_COUNT, 8'h00, 4'hF);
      chk8("cap_width", 8'h14, rd);
      rd_chk("cap_ctrl", TEC_IDX_CTRL, 8'hC8);
      chk8("cap_active", 8'h00, {7'h0, count_active});
      // capture a 10-cycle low pulse, start on falling edge
      wr(TEC_IDX_CTRL, 8'hC0);
      wr(TEC_IDX_COUNT, 8'h00);
      u_src.level(1'b1, 6);
      wr(TEC_IDX_CTRL, 8'hD0);
      u_src.level(1'b0, 10);
      u_src.level(1'b1, 6);
      rd_chk("cap_low_width", TEC_IDX_COUNT, 8'h0A);
      rd_chk("cap_low_ctrl", TEC_IDX_CTRL, 8'hC0);
      results();
   end
endmodule // tb
